// File: hw/dam_move_unit.sv
// Accumulator move unit: instruction port, accumulators, APB registers
// Summary of operation
// - Move-from-upper copies the selected accumulator's upper half to a register.
// - Upper half is accumulator bits 63..32 for every move.
// - Lower half is accumulator bits 31..0 for every move.
// - Select picks accumulator 0 to 3; 0 is the legacy result pair.
// - Accumulators 1-3 with DSP disabled fault and skip the transfer.
// - Move-from-lower copies the selected lower half to a register.
// - Move-to-upper writes the upper half, lower half kept.
// - Move-to-lower writes the lower half, upper half kept.
// - Index decrement at zero returns the top index, second source 23..8.
// - Otherwise it returns first source minus byte size, bits 7..0.
// - Index decrement encoding; flag field of control word untouched.
// - Index decrement raises no data-dependent fault.
// - Shift-insert moves lower to upper and source into lower, at once.
// - Shift-insert encoding; flag field of control word untouched.
`include "dam_map.svh"
module dam_move_unit
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ins_valid,
	input wire logic [31:0] ins_word,
	input wire logic [31:0] ins_first_source,
	input wire logic [31:0] ins_second_source,
	output logic ins_ready,
	output logic res_valid,
	output logic res_we,
	output logic [31:0] res_data,
	output logic [4:0] res_dest,
	output logic dsp_disabled_fault,
	output logic reserved_fault,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	import dam_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Reset release
	logic [1:0] rst_pipe_r;
	logic rst_sync_b;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rst_pipe_r <= 2'b00;
		else
			rst_pipe_r <= {rst_pipe_r[0], 1'b1};
	end
	assign rst_sync_b = rst_pipe_r[1];

	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic reg_hit(input logic [11:0] a);
		reg_hit = a == `DAM_OFF_CTRL || a == `DAM_OFF_DSPCTL ||
			a == `DAM_OFF_STATUS;
	endfunction

	function automatic logic [31:0] index_step(input logic [31:0] s1,
		input logic [31:0] s2);
		if (s1 == 32'h0)
			index_step = {16'h0, s2[23:8]};
		else
			index_step = s1 - {24'h0, s2[7:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Decode and accumulator storage
	dam_core_t r;
	dam_core_t r_nxt;
	dam_op_t d_op;
	logic [1:0] d_acc;
	logic [4:0] d_dest;
	logic d_dis;
	logic [63:0] acc_rd;
	logic wr_hi_en;
	logic wr_lo_en;
	logic [31:0] wr_hi;
	logic [31:0] wr_lo;
	logic apb_acc;
	logic apb_wr;
	logic [31:0] acc_hi;
	logic [31:0] acc_lo;
	logic [15:0] src2_top;
	logic [7:0] src2_size;
	logic [5:0] pos;
	logic [25:0] ctl_upper;

	dam_decoder u_dec
	(
		.word(ins_word),
		.dsp_module_enable_bit(r.en),
		.op(d_op),
		.accumulator_select(d_acc),
		.dest(d_dest),
		.dsp_disabled_fault(d_dis)
	);

	dam_acc_mem #(
		.ACC_N(4),
		.HALF_W(32)
	) u_mem
	(
		.clk(clk),
		.rst_sync_b(rst_sync_b),
		.rd_sel(d_acc),
		.rd_data(acc_rd),
		.wr_sel(r.acc),
		.wr_hi_en(wr_hi_en),
		.wr_lo_en(wr_lo_en),
		.wr_hi(wr_hi),
		.wr_lo(wr_lo)
	);

	assign acc_hi = acc_rd[63:32];
	assign acc_lo = acc_rd[31:0];
	assign src2_top = r.src2[23:8];
	assign src2_size = r.src2[7:0];
	assign pos = r.dspctl[5:0];
	assign ctl_upper = r.dspctl[31:6];
	assign apb_acc = psel && penable;
	assign apb_wr = apb_acc && pwrite && r.pready;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		r_nxt = r;
		r_nxt.res_valid = 1'b0;
		r_nxt.res_we = 1'b0;
		r_nxt.flt_dis = 1'b0;
		r_nxt.flt_ri = 1'b0;
		r_nxt.pready = 1'b0;
		wr_hi_en = 1'b0;
		wr_lo_en = 1'b0;
		wr_hi = r.src1;
		wr_lo = r.src1;

		// APB: one wait cycle, write lands on the completing edge
		if (apb_acc && !r.pready)
		begin
			r_nxt.pready = 1'b1;
			r_nxt.pslverr = !reg_hit(paddr);
			case (paddr)
				`DAM_OFF_CTRL: r_nxt.prdata = {31'h0, r.en};
				`DAM_OFF_DSPCTL: r_nxt.prdata = r.dspctl;
				`DAM_OFF_STATUS: r_nxt.prdata = {29'h0, r.ri_seen,
					r.dis_seen, r.state != ST_IDLE};
				default: r_nxt.prdata = 32'h0;
			endcase
		end
		if (apb_wr)
		begin
			case (paddr)
				`DAM_OFF_CTRL: r_nxt.en = pwdata[`DAM_CTRL_EN_BIT];
				`DAM_OFF_DSPCTL: r_nxt.dspctl = pwdata;
				`DAM_OFF_STATUS:
				begin
					if (pwdata[`DAM_ST_DIS_BIT])
						r_nxt.dis_seen = 1'b0;
					if (pwdata[`DAM_ST_RI_BIT])
						r_nxt.ri_seen = 1'b0;
				end
				default: r_nxt.en = r.en;
			endcase
		end

		// Instruction sequence: accept, then execute with interlock
		case (r.state)
			ST_IDLE:
			begin
				if (ins_valid)
				begin
					r_nxt.state = ST_EXEC;
					r_nxt.ins_ready = 1'b0;
					r_nxt.op = d_op;
					r_nxt.acc = d_acc;
					r_nxt.dest = d_dest;
					r_nxt.src1 = ins_first_source;
					r_nxt.src2 = ins_second_source;
					r_nxt.dis = d_dis;
					r_nxt.ri = d_op == OP_NONE;
				end
			end
			ST_EXEC:
			begin
				r_nxt.state = ST_IDLE;
				r_nxt.ins_ready = 1'b1;
				r_nxt.res_valid = 1'b1;
				r_nxt.res_dest = r.dest;
				r_nxt.flt_dis = r.dis;
				r_nxt.flt_ri = r.ri;
				if (r.dis)
					r_nxt.dis_seen = 1'b1;
				if (r.ri)
					r_nxt.ri_seen = 1'b1;
				if (!r.dis && !r.ri)
				begin
					case (r.op)
						OP_MFU:
						begin
							r_nxt.res_we = 1'b1;
							r_nxt.res_data = acc_rd[63:32];
						end
						OP_MFL:
						begin
							r_nxt.res_we = 1'b1;
							r_nxt.res_data = acc_rd[31:0];
						end
						OP_MTU: wr_hi_en = 1'b1;
						OP_MTL: wr_lo_en = 1'b1;
						OP_MODDEC:
						begin
							r_nxt.res_we = 1'b1;
							r_nxt.res_data = index_step(r.src1, r.src2);
						end
						OP_SHINS:
						begin
							wr_hi_en = 1'b1;
							wr_lo_en = 1'b1;
							wr_hi = acc_rd[31:0];
							r_nxt.dspctl[5:0] = pos + `DAM_POS_STEP;
						end
						default: r_nxt.res_we = 1'b0;
					endcase
				end
			end
			default:
			begin
				r_nxt.state = ST_IDLE;
				r_nxt.ins_ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			r <= '0;
			r.ins_ready <= 1'b1;
			r.dspctl <= `DAM_DSPCTL_RST;
		end
		else
			r <= r_nxt;
	end

	assign ins_ready = r.ins_ready;
	assign res_valid = r.res_valid;
	assign res_we = r.res_we;
	assign res_data = r.res_data;
	assign res_dest = r.res_dest;
	assign dsp_disabled_fault = r.flt_dis;
	assign reserved_fault = r.flt_ri;
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking dam_cb @(posedge clk);
	endclocking
	default disable iff (!rst_sync_b);

	sequence s_accept;
		r.state == ST_IDLE && ins_valid;
	endsequence
	sequence s_exec_ok(dam_op_t o);
		r.state == ST_EXEC && r.op == o && !r.dis && !r.ri;
	endsequence
	sequence s_busy_then_free;
		!ins_ready ##1 ins_ready;
	endsequence

	chk_upper_read_data: assert property (s_exec_ok(OP_MFU) |=>
		res_valid && res_we && res_data == $past(acc_hi))
		else $error("move from upper returned wrong data");
	chk_lower_read_data: assert property (s_exec_ok(OP_MFL) |=>
		res_valid && res_we && res_data == $past(acc_lo))
		else $error("move from lower returned wrong data");
	chk_disabled_fault: assert property (s_accept ##0 d_dis |=>
		##1 (dsp_disabled_fault && res_valid && !res_we))
		else $error("disabled access not faulted or not blocked");
	chk_interlock_stall: assert property (s_accept |=>
		s_busy_then_free)
		else $error("issue not stalled for one execute cycle");
	chk_index_wrap: assert property (s_exec_ok(OP_MODDEC) ##0
		r.src1 == 32'h0 |=> res_we && res_data == {16'h0, $past(src2_top)})
		else $error("index decrement did not wrap to top");
	chk_index_step: assert property (s_exec_ok(OP_MODDEC) ##0
		r.src1 != 32'h0 |=>
		res_we && res_data == $past(r.src1) - {24'h0, $past(src2_size)})
		else $error("index decrement wrong difference");
	chk_pos_advance: assert property (s_exec_ok(OP_SHINS) ##0 !apb_wr |=>
		pos == $past(pos) + `DAM_POS_STEP && !res_we)
		else $error("position field not advanced by 32");
	chk_flags_untouched: assert property (r.state == ST_EXEC &&
		!apb_wr |=> $stable(ctl_upper))
		else $error("control word flag field changed");
endmodule // dam_move_unit

// File: hw/dam_map.svh
// Offsets, field positions, encodings and reset values of the move unit
`ifndef DAM_MAP_SVH
`define DAM_MAP_SVH
`define DAM_OFF_CTRL 12'h000
`define DAM_OFF_DSPCTL 12'h004
`define DAM_OFF_STATUS 12'h008
`define DAM_CTRL_EN_BIT 0
`define DAM_ST_BUSY_BIT 0
`define DAM_ST_DIS_BIT 1
`define DAM_ST_RI_BIT 2
`define DAM_POS_STEP 6'h20
`define DAM_DSPCTL_RST 32'h0000_0000
`define DAM_CLS_BASE 6'h00
`define DAM_CLS_EXT 6'h1f
`define DAM_FN_MFU 6'h10
`define DAM_FN_MTU 6'h11
`define DAM_FN_MFL 6'h12
`define DAM_FN_MTL 6'h13
`define DAM_SUB_MODDEC 5'h12
`define DAM_FN_MODDEC 6'h10
`define DAM_SUB_SHINS 5'h1f
`define DAM_FN_SHINS 6'h38
`endif

// File: hw/dam_pkg.sv
// Types shared by the accumulator move unit
package dam_pkg;
	typedef enum logic [2:0]
	{
		OP_NONE,
		OP_MFU,
		OP_MFL,
		OP_MTU,
		OP_MTL,
		OP_MODDEC,
		OP_SHINS
	} dam_op_t;
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01
	} dam_state_t;
	typedef struct packed
	{
		dam_state_t state;
		dam_op_t op;
		logic [1:0] acc;
		logic [4:0] dest;
		logic [31:0] src1;
		logic [31:0] src2;
		logic dis;
		logic ri;
		logic ins_ready;
		logic res_valid;
		logic res_we;
		logic [31:0] res_data;
		logic [4:0] res_dest;
		logic flt_dis;
		logic flt_ri;
		logic en;
		logic [31:0] dspctl;
		logic dis_seen;
		logic ri_seen;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} dam_core_t;
endpackage

// File: hw/dam_acc_mem.sv
// Accumulator storage with split half writes and registered read
module dam_acc_mem #(
	parameter int ACC_N = 4,
	parameter int HALF_W = 32
)
(
	input wire logic clk,
	input wire logic rst_sync_b,
	input wire logic [1:0] rd_sel,
	output logic [2*HALF_W-1:0] rd_data,
	input wire logic [1:0] wr_sel,
	input wire logic wr_hi_en,
	input wire logic wr_lo_en,
	input wire logic [HALF_W-1:0] wr_hi,
	input wire logic [HALF_W-1:0] wr_lo
);
	typedef struct packed
	{
		logic [ACC_N-1:0][2*HALF_W-1:0] acc;
		logic [2*HALF_W-1:0] rd;
	} dam_mem_t;
	dam_mem_t r;
	dam_mem_t r_nxt;
	logic [HALF_W-1:0] lo_at_sel;
	logic [HALF_W-1:0] hi_at_sel;

	assign rd_data = r.rd;
	assign lo_at_sel = r.acc[wr_sel][HALF_W-1:0];
	assign hi_at_sel = r.acc[wr_sel][2*HALF_W-1:HALF_W];

	always_comb
	begin
		r_nxt = r;
		r_nxt.rd = r.acc[rd_sel];
		if (wr_hi_en)
			r_nxt.acc[wr_sel][2*HALF_W-1:HALF_W] = wr_hi;
		if (wr_lo_en)
			r_nxt.acc[wr_sel][HALF_W-1:0] = wr_lo;
	end

	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			r <= '0;
		else
			r <= r_nxt;
	end

	chk_upper_only_write: assert property (@(posedge clk)
		disable iff (!rst_sync_b)
		wr_hi_en && !wr_lo_en |=>
		r.acc[$past(wr_sel)][HALF_W-1:0] == $past(lo_at_sel) &&
		r.acc[$past(wr_sel)][2*HALF_W-1:HALF_W] == $past(wr_hi))
		else $error("upper write disturbed lower half");
	chk_lower_only_write: assert property (@(posedge clk)
		disable iff (!rst_sync_b)
		wr_lo_en && !wr_hi_en |=>
		r.acc[$past(wr_sel)][2*HALF_W-1:HALF_W] == $past(hi_at_sel) &&
		r.acc[$past(wr_sel)][HALF_W-1:0] == $past(wr_lo))
		else $error("lower write disturbed upper half");
endmodule // dam_acc_mem

// File: hw/dam_decoder.sv
// Instruction decode and fault screening for the move unit
`include "dam_map.svh"
module dam_decoder
(
	input wire logic [31:0] word,
	input wire logic dsp_module_enable_bit,
	output dam_pkg::dam_op_t op,
	output logic [1:0] accumulator_select,
	output logic [4:0] dest,
	output logic dsp_disabled_fault
);
	import dam_pkg::*;
	logic [5:0] cls;
	logic [5:0] fn;
	logic [4:0] sub;

	assign cls = word[31:26];
	assign fn = word[5:0];
	assign sub = word[10:6];
	assign dest = word[15:11];

	always_comb
	begin
		op = OP_NONE;
		accumulator_select = word[12:11];
		if (cls == `DAM_CLS_BASE)
		begin
			case (fn)
				`DAM_FN_MFU:
				begin
					op = OP_MFU;
					accumulator_select = word[22:21];
				end
				`DAM_FN_MFL:
				begin
					op = OP_MFL;
					accumulator_select = word[22:21];
				end
				`DAM_FN_MTU: op = OP_MTU;
				`DAM_FN_MTL: op = OP_MTL;
				default: op = OP_NONE;
			endcase
		end
		else if (cls == `DAM_CLS_EXT)
		begin
			if (sub == `DAM_SUB_MODDEC && fn == `DAM_FN_MODDEC)
				op = OP_MODDEC;
			else if (sub == `DAM_SUB_SHINS && fn == `DAM_FN_SHINS)
				op = OP_SHINS;
		end
	end

	always_comb
	begin
		case (op)
			OP_MFU, OP_MFL, OP_MTU, OP_MTL:
				dsp_disabled_fault = accumulator_select != 2'h0 &&
					!dsp_module_enable_bit;
			OP_MODDEC, OP_SHINS:
				dsp_disabled_fault = !dsp_module_enable_bit;
			default: dsp_disabled_fault = 1'b0;
		endcase
	end
endmodule // dam_decoder

// File: tb/dam_core_model.sv
// Core-side model: offers instruction words and collects the results
module dam_core_model
(
	input wire logic clk,
	input wire logic ins_ready,
	input wire logic res_valid,
	input wire logic res_we,
	input wire logic [31:0] res_data,
	input wire logic [4:0] res_dest,
	input wire logic dsp_disabled_fault,
	input wire logic reserved_fault,
	output logic ins_valid,
	output logic [31:0] ins_word,
	output logic [31:0] ins_first_source,
	output logic [31:0] ins_second_source
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] got_data;
	logic [4:0] got_dest;
	logic [2:0] got_flg;
	initial
	begin
		ins_valid = 1'b0;
		ins_word = 32'h0000_0000;
		ins_first_source = 32'h0000_0000;
		ins_second_source = 32'h0000_0000;
	end
	// Offer, hold until taken, then collect; no product is ever pending
	task automatic issue(input logic [31:0] w, input logic [31:0] a,
		input logic [31:0] b, input int gap);
		int n;
		n = 0;
		repeat (gap) @(posedge clk);
		ins_valid <= 1'b1;
		ins_word <= w;
		ins_first_source <= a;
		ins_second_source <= b;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ins_ready !== 1'b1 && n < 100);
		// Released lines carry the inverse, not the old value
		ins_valid <= 1'b0;
		ins_word <= ~w;
		ins_first_source <= ~a;
		ins_second_source <= ~b;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (res_valid !== 1'b1 && n < 200);
		got_data = res_data;
		got_dest = res_dest;
		// A missing answer reads as an impossible flag set
		if (res_valid !== 1'b1)
			got_flg = 3'b111;
		else
			got_flg = {res_we, dsp_disabled_fault, reserved_fault};
	endtask
endmodule // dam_core_model

// File: tb/dam_move_unit_bench.sv
// Self-checking bench of the accumulator move unit
`include "dam_map.svh"
module dam_move_unit_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, ins_word, ins_s1, ins_s2, res_data;
	logic [4:0] res_dest;
	logic pready, pslverr, ins_valid, ins_ready, res_valid, res_we;
	logic dis_f, ri_f;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	int k;
	logic [31:0] hv;
	always #4 clk = ~clk;
	dam_move_unit u_dam_move_unit (.clk(clk), .rst_b(rst_b),
		.ins_valid(ins_valid), .ins_word(ins_word),
		.ins_first_source(ins_s1), .ins_second_source(ins_s2),
		.ins_ready(ins_ready), .res_valid(res_valid), .res_we(res_we),
		.res_data(res_data), .res_dest(res_dest),
		.dsp_disabled_fault(dis_f), .reserved_fault(ri_f), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	dam_core_model u_dam_core_model (.clk(clk), .ins_ready(ins_ready),
		.res_valid(res_valid), .res_we(res_we), .res_data(res_data),
		.res_dest(res_dest), .dsp_disabled_fault(dis_f),
		.reserved_fault(ri_f), .ins_valid(ins_valid), .ins_word(ins_word),
		.ins_first_source(ins_s1), .ins_second_source(ins_s2));
	task automatic complete_run();
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			failures++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] d,
		input logic e);
		logic [31:0] q;
		logic qe;
		apb(1'b0, a, 32'h0, q, qe);
		check("prdata", q, d);
		check("pslverr", {31'h0, qe}, {31'h0, e});
	endtask
	function automatic logic [31:0] fw(input logic [5:0] fn,
		input logic [1:0] ac, input logic [4:0] rd);
		return {`DAM_CLS_BASE, 3'b000, ac, 5'h00, rd, 5'h00, fn};
	endfunction
	function automatic logic [31:0] tw(input logic [5:0] fn,
		input logic [1:0] ac);
		return {`DAM_CLS_BASE, 5'h00, 8'h00, ac, 5'h00, fn};
	endfunction
	function automatic logic [31:0] ex(input logic [4:0] sub,
		input logic [5:0] fn, input logic [4:0] rd);
		return {`DAM_CLS_EXT, 10'h000, rd, sub, fn};
	endfunction
	// Issue one word; f is {write back, disabled fault, reserved fault}
	task automatic run(input logic [31:0] w, input logic [31:0] a,
		input logic [31:0] b, input logic [31:0] d, input logic [2:0] f);
		u_dam_core_model.issue(w, a, b, f[2] ? 0 : 1);
		check("flags", {29'h0, u_dam_core_model.got_flg}, {29'h0, f});
		if (f[2])
		begin
			check("data", u_dam_core_model.got_data, d);
			check("dest", {27'h0, u_dam_core_model.got_dest},
				{27'h0, w[15:11]});
		end
	endtask
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			failures++;
			complete_run();
		end
	end
	initial
	begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		rd(`DAM_OFF_DSPCTL, `DAM_DSPCTL_RST, 1'b0);
		rd(12'h00c, 32'h0, 1'b1);
		run(tw(`DAM_FN_MTU, 2'd0), 32'h1234_5678, 0, 0, 3'b000);
		run(tw(`DAM_FN_MTL, 2'd0), 32'h9abc_def0, 0, 0, 3'b000);
		run(fw(`DAM_FN_MFU, 2'd0, 5'd3), 0, 0, 32'h1234_5678, 3'b100);
		run(fw(`DAM_FN_MFL, 2'd0, 5'd4), 0, 0, 32'h9abc_def0, 3'b100);
		run(ex(`DAM_SUB_MODDEC, `DAM_FN_MODDEC, 5'd9), 0, 1, 0, 3'b010);
		for (k = 1; k < 4; k++)
		begin
			run(tw(`DAM_FN_MTU, k[1:0]), 32'hdead_beef, 0, 0, 3'b010);
			run(fw(`DAM_FN_MFL, k[1:0], 5'd1), 0, 0, 0, 3'b010);
		end
		wr(`DAM_OFF_CTRL, 32'h1);
		rd(`DAM_OFF_CTRL, 32'h1, 1'b0);
		for (k = 1; k < 4; k++)
		begin
			hv = 32'h1111_1111 * 32'(k);
			run(fw(`DAM_FN_MFU, k[1:0], 5'd2), 0, 0, 0, 3'b100);
			run(tw(`DAM_FN_MTU, k[1:0]), hv, 0, 0, 3'b000);
			run(tw(`DAM_FN_MTL, k[1:0]), ~hv, 0, 0, 3'b000);
		end
		for (k = 1; k < 4; k++)
		begin
			hv = 32'h1111_1111 * 32'(k);
			run(fw(`DAM_FN_MFU, k[1:0], 5'd5), 0, 0, hv, 3'b100);
			run(fw(`DAM_FN_MFL, k[1:0], 5'd6), 0, 0, ~hv, 3'b100);
		end
		run(fw(`DAM_FN_MFU, 2'd0, 5'd7), 0, 0, 32'h1234_5678, 3'b100);
		wr(`DAM_OFF_DSPCTL, 32'h00ff_0000);
		hv = ex(`DAM_SUB_MODDEC, `DAM_FN_MODDEC, 5'd8);
		run(hv, 0, 32'h00ab_cd10, 32'h0000_abcd, 3'b100);
		run(hv, 32'h100, 32'h00ab_cd10, 32'hf0, 3'b100);
		run(hv, 32'h5, 32'h0000_0007, 32'hffff_fffe, 3'b100);
		rd(`DAM_OFF_DSPCTL, 32'h00ff_0000, 1'b0);
		hv = ex(`DAM_SUB_SHINS, `DAM_FN_SHINS, 5'd1);
		run(hv, 32'hcafe_0001, 0, 0, 3'b000);
		run(fw(`DAM_FN_MFU, 2'd1, 5'd9), 0, 0, ~32'h1111_1111, 3'b100);
		run(fw(`DAM_FN_MFL, 2'd1, 5'd9), 0, 0, 32'hcafe_0001, 3'b100);
		rd(`DAM_OFF_DSPCTL, 32'h00ff_0020, 1'b0);
		run(ex(`DAM_SUB_SHINS, `DAM_FN_SHINS, 5'd0), 1, 0, 0, 3'b000);
		run(fw(`DAM_FN_MFU, 2'd0, 5'd9), 0, 0, 32'h9abc_def0, 3'b100);
		run(32'hfc00_003f, 0, 0, 0, 3'b001);
		hv = (32'h1 << `DAM_ST_DIS_BIT) | (32'h1 << `DAM_ST_RI_BIT);
		rd(`DAM_OFF_STATUS, hv, 1'b0);
		wr(`DAM_OFF_STATUS, hv);
		rd(`DAM_OFF_STATUS, 32'h0, 1'b0);
		complete_run();
	end
endmodule // dam_move_unit_bench
